// ==== hw/phybc_pkg.sv ====
// Constants, types and register map of the PHY basic control register bank
package phybc_pkg;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned SRST_TIME_NS = 1000;
  localparam int unsigned SRST_CYCLES =
    (SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEAD_TIME_US = 500;
  localparam int unsigned DEAD_CYCLES_DEF =
    (DEAD_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned DEAD_CNT_W = 16;
  localparam int unsigned SRST_CNT_W = 8;

  // Register bus
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;

  // Register offsets
  localparam logic [4:0] OFS_BASIC_MODE_CONTROL = 5'h00;
  localparam logic [4:0] OFS_PORT_STATUS = 5'h10;
  localparam logic [4:0] OFS_INT_STATUS = 5'h11;
  localparam logic [4:0] OFS_INT_CLEAR = 5'h12;
  localparam logic [4:0] OFS_INT_ENABLE = 5'h13;
  localparam logic [4:0] OFS_LINK_QUALITY_MONITOR_CONTROL = 5'h1d;
  localparam logic [4:0] OFS_LINK_QUALITY_DATA = 5'h1e;

  // Basic mode control fields
  localparam int unsigned BMC_RESET_BIT = 15;
  localparam int unsigned BMC_LOOPBACK_BIT = 14;
  localparam int unsigned BMC_SPEED_BIT = 13;
  localparam int unsigned BMC_AUTONEG_BIT = 12;
  localparam int unsigned BMC_DUPLEX_BIT = 8;
  localparam logic BMC_RESET_DEF = 1'b0;
  localparam logic BMC_LOOPBACK_DEF = 1'b0;

  // Port status fields
  localparam int unsigned PST_DEAD_BIT = 0;
  localparam int unsigned PST_FIXED_BIT = 1;
  localparam int unsigned PST_LINK_BIT = 2;
  localparam logic PST_FIXED_VAL = 1'b1;

  // Link quality monitor control fields
  localparam int unsigned LQM_ON_BIT = 15;
  localparam int unsigned LQM_WARN_W = 10;
  localparam logic LQM_ON_DEF = 1'b0;

  // Link quality data fields
  localparam int unsigned LQD_SAMPLE_BIT = 13;
  localparam int unsigned LQD_SEL_LSB = 9;
  localparam int unsigned LQD_SEL_W = 3;
  localparam int unsigned LQD_VAL_W = 8;
  localparam logic [2:0] LQD_SEL_DEF = 3'h0;

  // Interrupt sources
  localparam int unsigned INT_W = 4;
  localparam int unsigned INT_SRST_DONE = 0;
  localparam int unsigned INT_LINK_DOWN = 1;
  localparam int unsigned INT_LQ_WARN = 2;
  localparam int unsigned INT_DEAD_END = 3;

  // One MII nibble lane
  typedef struct packed {
    logic en;
    logic [3:0] data;
  } phybc_mii_t;

  // Strap-controlled configuration
  typedef struct packed {
    logic speed100;
    logic autoneg;
    logic duplex;
  } phybc_cfg_t;

  // Software reset sequencer
  typedef enum logic [1:0] {
    RS_IDLE = 2'b00,
    RS_HOLD = 2'b01,
    RS_LOAD = 2'b11
  } phybc_rst_t;

endpackage

// ==== hw/phybc_top.sv ====
// PHY basic control register bank with loopback path and interrupt
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps

// Two-flop synchroniser for pins
module phybc_sync #(parameter int unsigned W = 1) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk)
  begin
    if (rst)
      {q, meta_r} <= '0;
    else
      {q, meta_r} <= {meta_r, d};
  end
endmodule

module phybc_top #(
  parameter int unsigned DEAD_CYCLES = phybc_pkg::DEAD_CYCLES_DEF
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic [phybc_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [phybc_pkg::DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [phybc_pkg::DATA_W-1:0] REG_RDATA,
  input wire phybc_pkg::phybc_cfg_t STRAP,
  input wire logic AN_SPEED100,
  input wire logic LINK_UP,
  input wire logic [phybc_pkg::LQM_WARN_W-1:0] LQ_WARN,
  input wire logic [phybc_pkg::LQD_VAL_W-1:0] LQ_VALUE,
  input wire phybc_pkg::phybc_mii_t MII_TX,
  input wire phybc_pkg::phybc_mii_t LINE_RX,
  output phybc_pkg::phybc_mii_t MII_RX,
  output logic SPEED_100,
  output logic FULL_DUPLEX,
  output logic AUTONEG_EN,
  output logic SOFT_RESET_BUSY,
  output logic [phybc_pkg::LQD_SEL_W-1:0] LQ_PARAM_SEL,
  output logic LQ_SAMPLE_REQ,
  output logic IRQ
);
  localparam int unsigned SYNC_W = 3 + 1 + 1 + phybc_pkg::LQM_WARN_W
    + phybc_pkg::LQD_VAL_W + 5 + 5;

  logic [SYNC_W-1:0] sync_q;
  phybc_pkg::phybc_cfg_t strap_s;
  logic an_speed_s, link_s;
  logic [phybc_pkg::LQM_WARN_W-1:0] warn_s;
  logic [phybc_pkg::LQD_VAL_W-1:0] value_s;
  phybc_pkg::phybc_mii_t tx_s, line_s;
  phybc_pkg::phybc_rst_t rst_st_r;
  logic [phybc_pkg::SRST_CNT_W-1:0] rst_cnt_r;
  phybc_pkg::phybc_cfg_t cfg_r;
  logic loopback_r, loop_prev_r, dead_r, dead_end;
  logic [phybc_pkg::DEAD_CNT_W-1:0] dead_cnt_r;
  logic link_ll_r, link_prev_r, lqm_on_r, sample_r;
  logic [phybc_pkg::LQM_WARN_W-1:0] warn_lh_r;
  logic [phybc_pkg::LQD_SEL_W-1:0] sel_r;
  logic [phybc_pkg::LQD_VAL_W-1:0] lq_val_r;
  logic [phybc_pkg::INT_W-1:0] int_stat_r, int_en_r, int_evt;
  logic [phybc_pkg::DATA_W-1:0] rd_nxt;
  logic busy, wr_bmc, rd_pst, rd_lqm, rd_lqd, wr_lqm, wr_lqd;

  // All pins but RESET and the register port pass two flops before any logic sees them
  phybc_sync #(.W(SYNC_W)) u_sync (
    .clk(SYS_CLK),
    .rst(RESET),
    .d({STRAP, AN_SPEED100, LINK_UP, LQ_WARN, LQ_VALUE, MII_TX, LINE_RX}),
    .q(sync_q)
  );

  assign {strap_s, an_speed_s, link_s, warn_s, value_s, tx_s, line_s} =
    sync_q;

  // Access decode
  assign busy = (rst_st_r != phybc_pkg::RS_IDLE);
  assign wr_bmc = REG_WR && REG_ADDR == phybc_pkg::OFS_BASIC_MODE_CONTROL;
  assign rd_pst = REG_RD && REG_ADDR == phybc_pkg::OFS_PORT_STATUS;
  assign rd_lqm = REG_RD
    && REG_ADDR == phybc_pkg::OFS_LINK_QUALITY_MONITOR_CONTROL;
  assign rd_lqd = REG_RD && REG_ADDR == phybc_pkg::OFS_LINK_QUALITY_DATA;
  assign wr_lqm = REG_WR
    && REG_ADDR == phybc_pkg::OFS_LINK_QUALITY_MONITOR_CONTROL;
  assign wr_lqd = REG_WR && REG_ADDR == phybc_pkg::OFS_LINK_QUALITY_DATA;

  // Reset sequencer; hardware reset also runs it so straps load after release
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      rst_st_r <= phybc_pkg::RS_HOLD;
      rst_cnt_r <= '0;
    end
    else
    begin
      case (rst_st_r)
        phybc_pkg::RS_IDLE:
        begin
          rst_cnt_r <= '0;
          if (wr_bmc && REG_WDATA[phybc_pkg::BMC_RESET_BIT])
            rst_st_r <= phybc_pkg::RS_HOLD;
        end
        phybc_pkg::RS_HOLD:
        begin
          rst_cnt_r <= rst_cnt_r + 1'b1;
          if (rst_cnt_r == phybc_pkg::SRST_CNT_W'(phybc_pkg::SRST_CYCLES - 1))
            rst_st_r <= phybc_pkg::RS_LOAD;
        end
        phybc_pkg::RS_LOAD:
          rst_st_r <= phybc_pkg::RS_IDLE;
        default:
          rst_st_r <= phybc_pkg::RS_IDLE;
      endcase
    end
  end

  // Strap-controlled configuration; writes during a reset are dropped
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
      cfg_r <= '0;
    else if (rst_st_r == phybc_pkg::RS_LOAD)
      cfg_r <= strap_s;
    else if (wr_bmc && !busy)
    begin
      cfg_r.speed100 <= REG_WDATA[phybc_pkg::BMC_SPEED_BIT];
      cfg_r.autoneg <= REG_WDATA[phybc_pkg::BMC_AUTONEG_BIT];
      cfg_r.duplex <= REG_WDATA[phybc_pkg::BMC_DUPLEX_BIT];
    end
  end

  // Loopback control bit, cleared by soft reset
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET || busy)
      loopback_r <= phybc_pkg::BMC_LOOPBACK_DEF;
    else if (wr_bmc)
      loopback_r <= REG_WDATA[phybc_pkg::BMC_LOOPBACK_BIT];
  end

  // Descrambler dead time after loopback is switched on
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      loop_prev_r <= 1'b0;
      dead_cnt_r <= '0;
      dead_r <= 1'b0;
    end
    else
    begin
      loop_prev_r <= loopback_r;
      if (loopback_r && !loop_prev_r)
      begin
        dead_r <= 1'b1;
        dead_cnt_r <= phybc_pkg::DEAD_CNT_W'(DEAD_CYCLES - 1);
      end
      else if (!loopback_r || dead_cnt_r == '0)
        dead_r <= 1'b0;
      else
        dead_cnt_r <= dead_cnt_r - 1'b1;
    end
  end

  assign dead_end = dead_r && (!loopback_r || dead_cnt_r == '0);

  // Receive path: loopback or line, blanked during dead time
  // The first loopback cycle is blanked too, before the dead flag is up
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
      MII_RX <= '0;
    else if (loopback_r && (dead_r || !loop_prev_r))
      MII_RX <= '0;
    else if (loopback_r)
      MII_RX <= tx_s;
    else
      MII_RX <= line_s;
  end

  // Mode outputs
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      SPEED_100 <= 1'b0;
      FULL_DUPLEX <= 1'b0;
      AUTONEG_EN <= 1'b0;
      SOFT_RESET_BUSY <= 1'b1;
    end
    else
    begin
      SPEED_100 <= cfg_r.autoneg ? an_speed_s : cfg_r.speed100;
      FULL_DUPLEX <= cfg_r.duplex;
      AUTONEG_EN <= cfg_r.autoneg;
      SOFT_RESET_BUSY <= busy;
    end
  end

  // Latched-low link status; a read clears the latch, a drop still wins
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      link_ll_r <= 1'b0;
      link_prev_r <= 1'b0;
    end
    else
    begin
      link_prev_r <= link_s;
      link_ll_r <= link_s & (link_ll_r | rd_pst);
    end
  end

  // Quality monitor control: enable bit and latched-high warnings
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET || busy)
    begin
      lqm_on_r <= phybc_pkg::LQM_ON_DEF;
      warn_lh_r <= '0;
    end
    else
    begin
      if (wr_lqm)
        lqm_on_r <= REG_WDATA[phybc_pkg::LQM_ON_BIT];
      // Warning bits are status only, writes never reach them
      warn_lh_r <= (warn_s & {phybc_pkg::LQM_WARN_W{lqm_on_r}})
        | (rd_lqm ? '0 : warn_lh_r);
    end
  end

  // Parameter select and the self-clearing sample request
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET || busy)
    begin
      sel_r <= phybc_pkg::LQD_SEL_DEF;
      sample_r <= 1'b0;
    end
    else
    begin
      if (wr_lqd)
        sel_r <= REG_WDATA[phybc_pkg::LQD_SEL_LSB +: phybc_pkg::LQD_SEL_W];
      if (wr_lqd && REG_WDATA[phybc_pkg::LQD_SAMPLE_BIT])
        sample_r <= 1'b1;
      else if (sample_r)
        sample_r <= 1'b0;
    end
  end

  // Sampled value: capture wins over the clear of a read in the same cycle
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET || busy)
      lq_val_r <= '0;
    else if (sample_r)
      lq_val_r <= value_s;
    else if (rd_lqd)
      lq_val_r <= '0;
  end

  assign LQ_PARAM_SEL = sel_r;
  assign LQ_SAMPLE_REQ = sample_r;

  // Interrupt sources
  assign int_evt[phybc_pkg::INT_SRST_DONE] = (rst_st_r == phybc_pkg::RS_LOAD);
  assign int_evt[phybc_pkg::INT_LINK_DOWN] = link_prev_r && !link_s;
  assign int_evt[phybc_pkg::INT_LQ_WARN] =
    |(warn_s & {phybc_pkg::LQM_WARN_W{lqm_on_r}});
  assign int_evt[phybc_pkg::INT_DEAD_END] = dead_end;

  // Sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      int_stat_r <= '0;
      int_en_r <= '0;
    end
    else
    begin
      if (REG_WR && REG_ADDR == phybc_pkg::OFS_INT_CLEAR)
        int_stat_r <= int_evt
          | (int_stat_r & ~REG_WDATA[phybc_pkg::INT_W-1:0]);
      else
        int_stat_r <= int_evt | int_stat_r;
      if (REG_WR && REG_ADDR == phybc_pkg::OFS_INT_ENABLE)
        int_en_r <= REG_WDATA[phybc_pkg::INT_W-1:0];
    end
  end

  // Level interrupt
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
      IRQ <= 1'b0;
    else
      IRQ <= |(int_stat_r & int_en_r);
  end

  // Read mux; unused and reserved positions stay zero
  always_comb
  begin
    rd_nxt = '0;
    if (REG_ADDR == phybc_pkg::OFS_BASIC_MODE_CONTROL)
    begin
      rd_nxt[phybc_pkg::BMC_RESET_BIT] = busy;
      rd_nxt[phybc_pkg::BMC_LOOPBACK_BIT] = loopback_r;
      rd_nxt[phybc_pkg::BMC_SPEED_BIT] = cfg_r.speed100;
      rd_nxt[phybc_pkg::BMC_AUTONEG_BIT] = cfg_r.autoneg;
      rd_nxt[phybc_pkg::BMC_DUPLEX_BIT] = cfg_r.duplex;
    end
    else if (REG_ADDR == phybc_pkg::OFS_PORT_STATUS)
    begin
      rd_nxt[phybc_pkg::PST_DEAD_BIT] = dead_r;
      rd_nxt[phybc_pkg::PST_FIXED_BIT] = phybc_pkg::PST_FIXED_VAL;
      rd_nxt[phybc_pkg::PST_LINK_BIT] = link_ll_r;
    end
    else if (REG_ADDR == phybc_pkg::OFS_INT_STATUS)
      rd_nxt[phybc_pkg::INT_W-1:0] = int_stat_r;
    else if (REG_ADDR == phybc_pkg::OFS_INT_ENABLE)
      rd_nxt[phybc_pkg::INT_W-1:0] = int_en_r;
    else if (REG_ADDR == phybc_pkg::OFS_LINK_QUALITY_MONITOR_CONTROL)
    begin
      rd_nxt[phybc_pkg::LQM_ON_BIT] = lqm_on_r;
      rd_nxt[phybc_pkg::LQM_WARN_W-1:0] = warn_lh_r;
    end
    else if (REG_ADDR == phybc_pkg::OFS_LINK_QUALITY_DATA)
    begin
      rd_nxt[phybc_pkg::LQD_SAMPLE_BIT] = sample_r;
      rd_nxt[phybc_pkg::LQD_SEL_LSB +: phybc_pkg::LQD_SEL_W] = sel_r;
      rd_nxt[phybc_pkg::LQD_VAL_W-1:0] = lq_val_r;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
      REG_RDATA <= '0;
    else if (REG_RD)
      REG_RDATA <= rd_nxt;
    else
      REG_RDATA <= '0;
  end
endmodule

// ==== test/phybc_props.sv ====
// Port-level assertions for the PHY basic control register bank
`timescale 1ns/1ps
module phybc_props #(
  parameter int unsigned DEAD_CYCLES = 20
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic [4:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [15:0] REG_RDATA,
  input wire phybc_pkg::phybc_mii_t MII_RX,
  input wire logic SOFT_RESET_BUSY,
  input wire logic LQ_SAMPLE_REQ
);
  logic lb_r;
  logic go_r;
  logic acc;
  logic wr0;
  logic rd0;
  // Busy pin lags the bank by a cycle, so the cycle after a reset write
  // already drops control writes
  assign acc = !SOFT_RESET_BUSY && !go_r;
  // Accepted control writes and reads of the mode register
  assign wr0 = REG_WR && REG_ADDR == 5'h00 && acc;
  assign rd0 = REG_RD && REG_ADDR == 5'h00;
  // Loopback mirror, so only an off-to-on write opens a dead time
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET || SOFT_RESET_BUSY || go_r)
      lb_r <= 1'b0;
    else if (wr0)
      lb_r <= REG_WDATA[14];
  end
  // Reset write accepted in the previous cycle
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
      go_r <= 1'b0;
    else
      go_r <= wr0 && REG_WDATA[15];
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  // Sample request: one cycle high, then low
  sequence s_pulse;
    LQ_SAMPLE_REQ ##1 !LQ_SAMPLE_REQ;
  endsequence
  // Receive lane blanked once the dead time is under way
  sequence s_dead;
    ##1 (MII_RX == 5'h00) [*8];
  endsequence
  a_busy_reads_one: assert property (rd0 |=>
    REG_RDATA[15] == SOFT_RESET_BUSY) else $error("reset bit");
  a_reset_starts: assert property (wr0 && REG_WDATA[15] |-> ##2
    SOFT_RESET_BUSY) else $error("soft reset not started");
  a_reset_ends: assert property ($rose(SOFT_RESET_BUSY) |->
    SOFT_RESET_BUSY [*8] ##[16:24] !SOFT_RESET_BUSY)
    else $error("soft reset length");
  a_sample_pulse: assert property (REG_WR && REG_ADDR == 5'h1e &&
    REG_WDATA[13] && acc |=> s_pulse)
    else $error("sample pulse");
  a_fixed_one: assert property (REG_RD && REG_ADDR == 5'h10 |=>
    REG_RDATA[1]) else $error("fixed bit");
  a_unmapped_zero: assert property (REG_RD && (REG_ADDR inside
    {[5'h01:5'h0f], [5'h14:5'h1c], 5'h1f}) |=> REG_RDATA == 16'h0000)
    else $error("unmapped read");
  a_dead_blank: assert property (wr0 && REG_WDATA[14] &&
    !REG_WDATA[15] && !lb_r |=> s_dead) else $error("dead time");
  a_mode_reserved: assert property (rd0 |=>
    (REG_RDATA & 16'h0eff) == 16'h0000) else $error("mode reserved");
  a_data_reserved: assert property (REG_RD && REG_ADDR == 5'h1e |=>
    (REG_RDATA & 16'hd100) == 16'h0000) else $error("data reserved");
endmodule
bind phybc_top phybc_props #(.DEAD_CYCLES(DEAD_CYCLES)) props_u (
  .SYS_CLK(SYS_CLK), .RESET(RESET), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .MII_RX(MII_RX),
  .SOFT_RESET_BUSY(SOFT_RESET_BUSY), .LQ_SAMPLE_REQ(LQ_SAMPLE_REQ));

// ==== test/tb_top.sv ====
// Self-checking testbench for the PHY basic control register bank
`timescale 1ns/1ps
module tb_top;
  localparam int DEAD = 20;
  logic clk, rst, wr, rd, an100, link, spd, fdx, anen, busy, smp, irq;
  logic [4:0] addr;
  logic [15:0] wdata, rdata, v;
  logic [9:0] warn;
  logic [7:0] lqv;
  logic [2:0] sel;
  phybc_pkg::phybc_cfg_t strap;
  phybc_pkg::phybc_mii_t tx, lrx, mrx;
  int errors, num_checks, cycles;
  phybc_top #(.DEAD_CYCLES(DEAD)) dut_u (.SYS_CLK(clk), .RESET(rst),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
    .REG_RDATA(rdata), .STRAP(strap), .AN_SPEED100(an100),
    .LINK_UP(link), .LQ_WARN(warn), .LQ_VALUE(lqv), .MII_TX(tx),
    .LINE_RX(lrx), .MII_RX(mrx), .SPEED_100(spd), .FULL_DUPLEX(fdx),
    .AUTONEG_EN(anen), .SOFT_RESET_BUSY(busy), .LQ_PARAM_SEL(sel),
    .LQ_SAMPLE_REQ(smp), .IRQ(irq));
  // Free-running 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Hang guard, far beyond the fewer than two hundred cycles the run needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] got,
    input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [4:0] a, input logic [15:0] e,
    input string nm);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
    chk(nm, v, e);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 60 && busy !== 1'b0; i++)
      @(negedge clk);
    chk("busy", {15'h0, busy}, 16'h0000);
  endtask
  task automatic t_srst();
    rd_reg(5'h00, 16'h8000, "boot busy");
    wait_idle();
    rd_reg(5'h00, 16'h2100, "boot mode");
    chk("speed", {14'h0, spd, fdx}, 16'h0003);
    strap <= 3'b000;
    an100 <= 1'b1;
    wr_reg(5'h00, 16'h8000);
    rd_reg(5'h00, 16'h8000, "soft busy");
    wait_idle();
    rd_reg(5'h00, 16'h0000, "restrap");
    chk("speed10", {15'h0, spd}, 16'h0000);
    wr_reg(5'h00, 16'h1000);
    repeat (4) @(negedge clk);
    chk("autoneg", {14'h0, anen, spd}, 16'h0003);
  endtask
  // Raise, mask and clear the reset-done event
  task automatic t_irq();
    rd_reg(5'h11, 16'h0001, "int status");
    wr_reg(5'h13, 16'h0001);
    repeat (2) @(negedge clk);
    chk("irq on", {15'h0, irq}, 16'h0001);
    wr_reg(5'h13, 16'h0000);
    repeat (2) @(negedge clk);
    chk("irq mask", {15'h0, irq}, 16'h0000);
    wr_reg(5'h13, 16'h0001);
    wr_reg(5'h12, 16'h0001);
    repeat (2) @(negedge clk);
    chk("irq clear", {15'h0, irq}, 16'h0000);
    rd_reg(5'h11, 16'h0000, "int cleared");
  endtask
  task automatic t_loop();
    chk("line rx", {11'h0, mrx}, 16'h0015);
    wr_reg(5'h00, 16'h4000);
    repeat (3) @(negedge clk);
    chk("dead rx", {11'h0, mrx}, 16'h0000);
    rd_reg(5'h10, 16'h0003, "dead flag");
    repeat (DEAD + 6) @(negedge clk);
    chk("loop rx", {11'h0, mrx}, 16'h001a);
    rd_reg(5'h10, 16'h0006, "dead over");
    wr_reg(5'h00, 16'h0000);
    repeat (4) @(negedge clk);
    chk("normal rx", {11'h0, mrx}, 16'h0015);
  endtask
  // Link drop latched low, write to status ignored
  task automatic t_latch();
    @(posedge clk);
    link <= 1'b0;
    repeat (5) @(posedge clk);
    link <= 1'b1;
    repeat (5) @(posedge clk);
    rd_reg(5'h10, 16'h0002, "link held");
    wr_reg(5'h10, 16'hfffd);
    rd_reg(5'h10, 16'h0006, "link live");
  endtask
  task automatic t_high();
    wr_reg(5'h1d, 16'h8000);
    @(posedge clk);
    warn <= 10'h201;
    repeat (5) @(posedge clk);
    warn <= 10'h000;
    repeat (5) @(posedge clk);
    rd_reg(5'h1d, 16'h8201, "warn held");
    rd_reg(5'h1d, 16'h8000, "warn live");
  endtask
  task automatic t_cor();
    wr_reg(5'h1e, 16'h2400);
    #1 chk("sample", {12'h0, smp, sel}, 16'h000a);
    rd_reg(5'h1e, 16'h045a, "value");
    rd_reg(5'h1e, 16'h0400, "value cleared");
    wr_reg(5'h1e, 16'h04a5);
    rd_reg(5'h1e, 16'h0400, "value write");
    wr_reg(5'h1f, 16'hffff);
    rd_reg(5'h1f, 16'h0000, "unmapped");
    rd_reg(5'h05, 16'h0000, "unmapped");
  endtask
  // Every input settled at time zero, then reset for ten cycles
  initial
  begin
    rst = 1'b1;
    {addr, wdata, wr, rd, an100, warn} = '0;
    strap = 3'b101;
    link = 1'b1;
    lqv = 8'h5a;
    tx = 5'h1a;
    lrx = 5'h15;
    {errors, num_checks, cycles} = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_srst();
    t_irq();
    t_loop();
    t_latch();
    t_high();
    t_cor();
    close_out();
  end
endmodule
